// file: design/sai_io_sequencer.sv
// Serial access sequencer: shift-clock link logic plus conversion control
`timescale 1ns/100ps
module sai_io_sequencer
  import sai_pkg::*;
#(
  parameter int NUM_INPUTS = NUM_AIN,       // Analog channels
  parameter int IN_W       = AIN_W,         // Signed sample width
  parameter int CS_SETUP   = CS_SETUP_CYC,  // Chip select filter cycles
  parameter int ABORT_WIN  = ABORT_CYC      // Abort window cycles
) (
  input  wire logic                       clock_i,          // System clock, 25 MHz
  input  wire logic                       rst_i,            // Synchronous reset
  input  wire logic                       io_clk_i,         // Host shift clock
  input  wire logic                       cs_n_i,           // Chip select, active low
  input  wire logic                       data_in_i,        // Serial control input
  input  wire logic [NUM_INPUTS*IN_W-1:0] analog_inputs_i,  // Digitised input levels
  output logic                            data_out_o,       // Serial result output
  output logic                            data_out_oe_o,    // Result output enable
  output logic                            eoc_o,            // End of conversion
  output logic                            sampling_o,       // Input being sampled
  output logic                            power_down_o      // Software power-down
);

  // Link domain, rising shift clock
  typedef struct packed {
    logic [4:0] cnt;
    logic [6:0] shift;
    logic [7:0] ctrl;
  } sai_rise_t;

  // Link domain, falling shift clock
  typedef struct packed {
    logic [4:0] cnt;
    logic       dout;
    logic       track;
  } sai_fall_t;

  // System domain
  typedef struct packed {
    logic             cs_level;
    logic [TMR_W-1:0] cs_tmr;
    logic             done_seen;
    logic             eoc;
    logic [7:0]       ctrl;
    logic [11:0]      result;
    logic [15:0]      word;
    logic [TMR_W-1:0] age;
    logic             converting;
    logic             power_down;
  } sai_sys_t;

  sai_rise_t rise_r;
  sai_rise_t rise_nxt;
  sai_fall_t fall_r;
  sai_fall_t fall_nxt;
  sai_sys_t  sys_r;
  sai_sys_t  sys_nxt;
  logic      done_tgl_r;
  logic      done_tgl_nxt;

  logic                       link_clear;
  logic [2:0]                 lvl_sync;
  logic [NUM_INPUTS*IN_W-1:0] ain_sync;
  logic                       cs_sync;
  logic                       done_sync;
  logic                       track_sync;

  sai_conv_if conv ();

  function automatic logic [4:0] len_decode(input logic [1:0] code);
    if (code == LEN_CODE_8) begin
      len_decode = LEN_8;
    end else if (code == LEN_CODE_16) begin
      len_decode = LEN_16;
    end else begin
      len_decode = LEN_12;
    end
  endfunction : len_decode

  // Serial order of the result: bit k of the word leaves k-th
  function automatic logic [15:0] build_word(input logic [11:0] res,
                                             input logic [7:0]  ctl);
    logic [11:0] code;
    logic [15:0] w;
    code = ctl[CTRL_BIP_BIT] ? (res ^ BIP_FLIP) : res;
    w    = '0;
    for (int k = 0; k < RES_W; k++) begin
      if (!ctl[CTRL_LSB_FIRST_FLAG_BIT]) begin
        w[k] = code[RES_W-1-k];
      end else if (ctl[CTRL_LEN_HI:CTRL_LEN_LO] == LEN_CODE_8) begin
        if (k < 8) begin
          w[k] = code[k+4];
        end
      end else begin
        w[k] = code[k];
      end
    end
    build_word = w;
  endfunction : build_word

  function automatic logic [11:0] clamp(input logic signed [IN_W-1:0] v);
    if (v < 0) begin
      clamp = CODE_ZERO;
    end else if (v > $signed({2'b00, CODE_FULL})) begin
      clamp = CODE_FULL;
    end else begin
      clamp = v[11:0];
    end
  endfunction : clamp

  // ------------------------------------------------------------------
  // Crossings into the system domain
  // ------------------------------------------------------------------
  sai_sync #(
    .WIDTH (3)
  ) u_lvl_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .async_i ({fall_r.track, done_tgl_r, ~cs_n_i}),  // Select kept true: reset reads idle
    .sync_o  (lvl_sync)
  );

  sai_sync #(
    .WIDTH (NUM_INPUTS*IN_W)
  ) u_ain_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .async_i (analog_inputs_i),
    .sync_o  (ain_sync)
  );

  assign cs_sync    = ~lvl_sync[0];
  assign done_sync  = lvl_sync[1];
  assign track_sync = lvl_sync[2];

  sai_sar u_sar (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .conv    (conv.eng)
  );

  // Link logic held clear while the filtered chip select is high
  assign link_clear = sys_r.cs_level;

  // ------------------------------------------------------------------
  // Link domain: control byte capture on rising edges
  // ------------------------------------------------------------------
  always_comb begin
    logic [7:0] byte_in;
    logic [4:0] len_now;
    byte_in  = {rise_r.shift, data_in_i};
    len_now  = (rise_r.cnt == CTRL_BITS - 5'h01)
             ? len_decode(byte_in[CTRL_LEN_HI:CTRL_LEN_LO])
             : len_decode(rise_r.ctrl[CTRL_LEN_HI:CTRL_LEN_LO]);
    rise_nxt = rise_r;
    if (rise_r.cnt < CTRL_BITS) begin
      rise_nxt.shift = byte_in[6:0];
    end
    if (rise_r.cnt == CTRL_BITS - 5'h01) begin
      rise_nxt.ctrl = byte_in;
    end
    if (rise_r.cnt + 5'h01 == len_now) begin
      rise_nxt.cnt = '0;
    end else begin
      rise_nxt.cnt = rise_r.cnt + 5'h01;
    end
  end

  always_ff @(posedge io_clk_i or posedge link_clear) begin
    if (link_clear) begin
      rise_r <= '0;
    end else begin
      rise_r <= rise_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Link domain: result shift-out and sequencing on falling edges
  // ------------------------------------------------------------------
  always_comb begin
    logic [4:0] cnt_n;
    logic [4:0] fall_len;
    cnt_n        = fall_r.cnt + 5'h01;
    fall_len     = len_decode(rise_r.ctrl[CTRL_LEN_HI:CTRL_LEN_LO]);
    fall_nxt     = fall_r;
    done_tgl_nxt = done_tgl_r;
    fall_nxt.dout = sys_r.word[cnt_n[3:0]];
    if (cnt_n == TRACK_FALL) begin
      fall_nxt.track = 1'b1;
    end
    if (cnt_n == fall_len) begin
      fall_nxt.cnt   = '0;
      fall_nxt.track = 1'b0;
      done_tgl_nxt   = ~done_tgl_r;
    end else begin
      fall_nxt.cnt = cnt_n;
    end
  end

  always_ff @(negedge io_clk_i or posedge link_clear) begin
    if (link_clear) begin
      fall_r <= '0;
    end else begin
      fall_r <= fall_nxt;
    end
  end

  // Survives chip select going high right after the last edge
  always_ff @(negedge io_clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_tgl_r <= 1'b0;
    end else begin
      done_tgl_r <= done_tgl_nxt;
    end
  end

  // First bit straight from the output register before any falling edge
  assign data_out_o    = (fall_r.cnt == 5'h00) ? sys_r.word[0] : fall_r.dout;
  assign data_out_oe_o = ~sys_r.cs_level;

  // ------------------------------------------------------------------
  // System domain: chip select filter, conversion control
  // ------------------------------------------------------------------
  always_comb begin
    logic       new_access;
    logic       start_evt;
    logic [3:0] ch;
    logic [11:0] tgt;
    sys_nxt     = sys_r;
    conv.start  = 1'b0;
    conv.abort  = 1'b0;
    ch          = rise_r.ctrl[CTRL_CH_HI:CTRL_CH_LO];
    tgt         = CODE_ZERO;
    new_access  = 1'b0;
    start_evt   = 1'b0;

    // Level must hold for the setup time before it counts
    if (cs_sync == sys_r.cs_level) begin
      sys_nxt.cs_tmr = '0;
    end else if (sys_r.cs_tmr == TMR_W'(CS_SETUP - 1)) begin
      sys_nxt.cs_tmr   = '0;
      sys_nxt.cs_level = cs_sync;
      new_access       = sys_r.cs_level;
    end else begin
      sys_nxt.cs_tmr = sys_r.cs_tmr + TMR_W'(1);
    end

    case (ch)
      CH_MID:  tgt = CODE_MID;
      CH_LOW:  tgt = CODE_ZERO;
      CH_HIGH: tgt = CODE_FULL;
      default: begin
        if (ch <= CH_LAST_AIN) begin
          tgt = clamp(ain_sync[int'(ch)*IN_W +: IN_W]);
        end
      end
    endcase
    conv.target = tgt;

    // Last falling edge seen through the toggle crossing
    start_evt          = done_sync ^ sys_r.done_seen;
    sys_nxt.done_seen  = done_sync;
    if (sys_r.converting && (sys_r.age != TMR_W'('1))) begin
      sys_nxt.age = sys_r.age + TMR_W'(1);
    end

    if (start_evt) begin
      sys_nxt.ctrl       = rise_r.ctrl;
      sys_nxt.eoc        = 1'b0;
      sys_nxt.age        = '0;
      sys_nxt.converting = 1'b1;
      sys_nxt.power_down = (ch == CH_PDOWN);
      conv.start         = (ch != CH_PDOWN);
    end else if (sys_r.converting && sys_r.power_down) begin
      sys_nxt.eoc        = 1'b1;
      sys_nxt.converting = 1'b0;
    end else if (conv.done) begin
      sys_nxt.result     = conv.result;
      sys_nxt.word       = build_word(conv.result, sys_r.ctrl);
      sys_nxt.eoc        = 1'b1;
      sys_nxt.converting = 1'b0;
    end else if (new_access && sys_r.converting
                 && (sys_r.age < TMR_W'(ABORT_WIN))) begin
      conv.abort         = 1'b1;
      sys_nxt.eoc        = 1'b1;
      sys_nxt.converting = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sys_r          <= '0;
      sys_r.cs_level <= 1'b1;
      sys_r.eoc      <= 1'b1;
      sys_r.ctrl     <= CTRL_RESET;
    end else begin
      sys_r <= sys_nxt;
    end
  end

  assign eoc_o        = sys_r.eoc;
  assign sampling_o   = track_sync;
  assign power_down_o = sys_r.power_down;

endmodule : sai_io_sequencer

// file: include/sai_pkg.sv
// Constants and field layout for the serial converter sequencer
// Notes on behaviour
// - Chip select high: shift clock and control input ignored, result output tri-stated.
// - Chip select falling starts an access and enables the result output.
// - Control byte: channel bits 7..4, length bits 3..2, LSB-first bit 1, bipolar bit 0.
// - Control byte captured on rising shift clock edges one to eight.
// - Control input ignored after the eighth shift clock in longer accesses.
// - With chip select held low, first result bit appears when EOC rises.
// - With chip select toggled, first result bit appears at chip select falling.
// - Each later result bit is shifted out on a falling shift clock edge.
// - Sampling starts at fourth falling edge and is held at the last one.
// - Last falling shift clock edge drives EOC low and starts conversion.
// - EOC rises once the result is latched into the output register, or at once on abort or power-down.
// - Conversion starts after the access, paced by the system clock, not the shift clock.
// - Chip select change counts only after being held for the setup time.
// - Power-up: EOC high and control register cleared to zero.
// - Chip select high then low resynchronises to a fresh access.
// - Control byte and result codes are positive logic.
// - Codes 0..10 pick inputs; 11 mid, 12 low, 13 high reference; 14 power-down.
// - Channel address applies to the conversion after the current access.
// - Length applies to current access: 01 eight, 11 sixteen, x0 twelve bits.
package sai_pkg;

  localparam int         RES_W          = 12;
  localparam int         WORD_W         = 16;
  localparam int         NUM_AIN        = 11;
  localparam int         AIN_W          = 14;
  localparam int         TMR_W          = 8;

  localparam int         CTRL_CH_HI     = 7;
  localparam int         CTRL_CH_LO     = 4;
  localparam int         CTRL_LEN_HI    = 3;
  localparam int         CTRL_LEN_LO    = 2;
  localparam int         CTRL_LSB_FIRST_FLAG_BIT  = 1;
  localparam int         CTRL_BIP_BIT   = 0;
  localparam logic [7:0] CTRL_RESET     = 8'h00;

  localparam logic [1:0] LEN_CODE_8     = 2'h1;
  localparam logic [1:0] LEN_CODE_16    = 2'h3;
  localparam logic [4:0] LEN_8          = 5'h08;
  localparam logic [4:0] LEN_12         = 5'h0C;
  localparam logic [4:0] LEN_16         = 5'h10;
  localparam logic [4:0] CTRL_BITS      = 5'h08;
  localparam logic [4:0] TRACK_FALL     = 5'h04;

  localparam logic [3:0] CH_LAST_AIN    = 4'hA;
  localparam logic [3:0] CH_MID         = 4'hB;
  localparam logic [3:0] CH_LOW         = 4'hC;
  localparam logic [3:0] CH_HIGH        = 4'hD;
  localparam logic [3:0] CH_PDOWN       = 4'hE;

  localparam logic [11:0] CODE_ZERO     = 12'h000;
  localparam logic [11:0] CODE_MID      = 12'h800;
  localparam logic [11:0] CODE_FULL     = 12'hFFF;
  localparam logic [11:0] BIP_FLIP      = 12'h800;

  localparam int         CLK_PERIOD_NS  = 40;
  localparam int         T_CS_SETUP_NS  = 1000;
  localparam int         CS_SETUP_CYC   = (T_CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         T_CONV_NS      = 8000;
  localparam int         CONV_CYC       = T_CONV_NS / CLK_PERIOD_NS;
  localparam int         SAR_STEP_CYC   = CONV_CYC / RES_W;
  localparam int         T_ABORT_NS     = 5000;
  localparam int         ABORT_CYC      = T_ABORT_NS / CLK_PERIOD_NS;

endpackage : sai_pkg

// file: include/sai_conv_if.sv
// Handshake between the sequencer and the approximation engine
`timescale 1ns/100ps
interface sai_conv_if;
  logic        start;
  logic        abort;
  logic [11:0] target;
  logic        busy;
  logic        done;
  logic [11:0] result;

  modport ctl (output start, output abort, output target,
               input busy, input done, input result);
  modport eng (input start, input abort, input target,
               output busy, output done, output result);
endinterface : sai_conv_if

// file: design/sai_sync.sv
// Two-flop synchroniser for levels entering the system clock domain
`timescale 1ns/100ps
module sai_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_i,  // System clock
  input  wire logic             rst_i,    // Synchronous reset
  input  wire logic [WIDTH-1:0] async_i,  // Foreign level
  output logic      [WIDTH-1:0] sync_o    // Synchronised level
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sai_sync_st_t;

  sai_sync_st_t st_r;
  sai_sync_st_t st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = async_i;
    st_nxt.sync = st_r.meta;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_o = st_r.sync;
endmodule : sai_sync

// file: design/sai_sar.sv
// Successive-approximation engine, one bit per paced step
`timescale 1ns/100ps
module sai_sar
  import sai_pkg::*;
(
  input  wire logic  clock_i,  // System clock
  input  wire logic  rst_i,    // Synchronous reset
  sai_conv_if.eng    conv      // Start, abort and result
);
  typedef enum logic [1:0] {
    SAR_IDLE = 2'b00,
    SAR_STEP = 2'b01,
    SAR_DONE = 2'b11
  } sai_sar_state_t;

  typedef struct packed {
    sai_sar_state_t state;
    logic [TMR_W-1:0] tick;
    logic [3:0]       bit_idx;
    logic [11:0]      approx;
    logic [11:0]      target;
  } sai_sar_st_t;

  sai_sar_st_t st_r;
  sai_sar_st_t st_nxt;

  always_comb begin
    logic [11:0] trial;
    trial  = st_r.approx | (12'h001 << st_r.bit_idx);
    st_nxt = st_r;
    case (st_r.state)
      SAR_IDLE: begin
        if (conv.start) begin
          st_nxt.state   = SAR_STEP;
          st_nxt.tick    = '0;
          st_nxt.bit_idx = 4'(RES_W - 1);
          st_nxt.approx  = CODE_ZERO;
          st_nxt.target  = conv.target;
        end
      end
      SAR_STEP: begin
        if (conv.abort) begin
          st_nxt.state = SAR_IDLE;
        end else if (st_r.tick == TMR_W'(SAR_STEP_CYC - 1)) begin
          st_nxt.tick = '0;
          if (trial <= st_r.target) begin
            st_nxt.approx = trial;
          end
          if (st_r.bit_idx == 4'h0) begin
            st_nxt.state = SAR_DONE;
          end else begin
            st_nxt.bit_idx = st_r.bit_idx - 4'h1;
          end
        end else begin
          st_nxt.tick = st_r.tick + TMR_W'(1);
        end
      end
      SAR_DONE: st_nxt.state = SAR_IDLE;
      default:  st_nxt.state = SAR_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign conv.busy   = (st_r.state != SAR_IDLE);
  assign conv.done   = (st_r.state == SAR_DONE);
  assign conv.result = st_r.approx;
endmodule : sai_sar

// file: tb/sai_seq_properties.sv
// Port-level timing checks for the serial converter sequencer
`timescale 1ns/100ps
module sai_seq_properties #(
  parameter int CS_SETUP = 25  // Chip select filter cycles
) (
  input  wire logic clock_i,        // System clock
  input  wire logic rst_i,          // Synchronous reset
  input  wire logic cs_n_i,         // Chip select, active low
  input  wire logic data_out_oe_o,  // Result output enable
  input  wire logic eoc_o,          // End of conversion
  input  wire logic sampling_o,     // Input being sampled
  input  wire logic power_down_o    // Software power-down
);
  logic [7:0] hi_r;
  logic [7:0] lo_r;

  // Cycles chip select has stood at its present level
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hi_r <= 8'h00;
      lo_r <= 8'h00;
    end else begin
      hi_r <= !cs_n_i ? 8'h00 : ((hi_r == 8'hFF) ? hi_r : hi_r + 8'h01);
      lo_r <= cs_n_i ? 8'h00 : ((lo_r == 8'hFF) ? lo_r : lo_r + 8'h01);
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_idle_hiz: assert property ((hi_r > CS_SETUP + 4) |-> !data_out_oe_o)
    else $error("result output driven while deselected");
  a_access_drive: assert property ((lo_r > CS_SETUP + 4) |-> data_out_oe_o)
    else $error("result output not driven while selected");
  a_cs_filter: assert property ($rose(data_out_oe_o) |-> (lo_r >= CS_SETUP))
    else $error("chip select accepted before setup time");
  a_power_up: assert property ($fell(rst_i) |-> eoc_o && !data_out_oe_o)
    else $error("wrong state after reset");
  a_sample_idle: assert property ($rose(sampling_o) |-> eoc_o)
    else $error("sampling began during a conversion");
  a_sample_conv: assert property ($fell(sampling_o) |-> ##[0:8] !eoc_o)
    else $error("no conversion after sampling ended");
  a_conv_bound: assert property ($fell(eoc_o) |-> ##[1:260] eoc_o)
    else $error("conversion did not finish in time");
  a_done_quiet: assert property ($rose(eoc_o) |-> !sampling_o)
    else $error("conversion done while sampling");
  a_pd_no_conv: assert property ($rose(power_down_o) |-> ##[0:3] eoc_o)
    else $error("power-down ran a conversion");
endmodule : sai_seq_properties

bind sai_io_sequencer sai_seq_properties #(.CS_SETUP(CS_SETUP)) i_props (
  .clock_i(clock_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .data_out_oe_o(data_out_oe_o),
  .eoc_o(eoc_o), .sampling_o(sampling_o), .power_down_o(power_down_o));

// file: tb/sai_host_model.sv
// Host serial port: chip select, idle-low shift clock, control byte
`timescale 1ns/100ps
module sai_host_model
  import sai_pkg::*;
#(
  parameter int CS_SETUP = 25  // Chip select filter cycles
) (
  input  wire logic clock_i,     // System clock, paces chip select
  input  wire logic data_out_i,  // Resolved serial result line
  output logic      cs_n_o,      // Chip select, active low
  output logic      io_clk_o,    // Shift clock
  output logic      data_in_o    // Control bit
);
  initial begin
    cs_n_o = 1'b1;
    io_clk_o = 1'b0;
    data_in_o = 1'b0;
  end

  // One access: optional select, n clocks, optional deselect
  task automatic access(input logic lo, input logic hi, input logic [7:0] b,
                        input int n, output logic [15:0] cap);
    int i;
    cap = 16'h0000;
    if (lo) begin
      @(posedge clock_i) cs_n_o <= 1'b0;
      repeat (CS_SETUP + 6) @(posedge clock_i);
    end
    #7;
    for (i = 0; i < n; i++) begin
      data_in_o = (i < 8) ? b[7 - i] : ~data_in_o;
      #15 io_clk_o = 1'b1;
      cap = {cap[14:0], data_out_i};
      #15 io_clk_o = 1'b0;
    end
    data_in_o = ~data_in_o;
    if (hi) begin
      repeat (10) @(posedge clock_i);
      cs_n_o <= 1'b1;
      repeat (CS_SETUP + 6) @(posedge clock_i);
    end
  endtask : access
endmodule : sai_host_model

// file: tb/sai_io_sequencer_tb_top.sv
// Self-checking bench for the serial converter sequencer
`timescale 1ns/100ps
module sai_io_sequencer_tb_top
  import sai_pkg::*;
();
  localparam int CSS   = 4;
  localparam int LIMIT = 20000;
  logic                    clk, rst, cs_n, io_clk, din, dout, oe, eoc, samp, pd;
  logic [NUM_AIN*AIN_W-1:0] ain;
  wire                     dout_w;
  int                      n_mismatch = 0;
  int                      checked = 0;
  int                      n_fall = 0;
  int                      n_samp = 0;
  int                      cyc = 0;
  logic [11:0]             res_q = CODE_ZERO;
  logic [7:0]              fmt_q = CTRL_RESET;

  assign dout_w = oe ? dout : 1'bz;

  sai_io_sequencer #(.CS_SETUP(CSS)) i_dut (
    .clock_i(clk), .rst_i(rst), .io_clk_i(io_clk), .cs_n_i(cs_n), .data_in_i(din),
    .analog_inputs_i(ain), .data_out_o(dout), .data_out_oe_o(oe), .eoc_o(eoc),
    .sampling_o(samp), .power_down_o(pd));
  sai_host_model #(.CS_SETUP(CSS)) i_host (
    .clock_i(clk), .data_out_i(dout_w), .cs_n_o(cs_n), .io_clk_o(io_clk), .data_in_o(din));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(negedge eoc) n_fall++;
  always @(posedge samp) n_samp++;
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("counts: %0d compared, %0d mismatched", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  task automatic cmp_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_word

  task automatic cmp_bit(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask : cmp_bit

  function automatic logic [11:0] raw(input logic [3:0] ch);
    logic signed [13:0] v;
    v = ain[int'(ch) * AIN_W +: AIN_W];
    if (ch <= CH_LAST_AIN) raw = (v < 0) ? CODE_ZERO : ((v > 4095) ? CODE_FULL : v[11:0]);
    else if (ch == CH_MID) raw = CODE_MID;
    else if (ch == CH_HIGH) raw = CODE_FULL;
    else raw = CODE_ZERO;
  endfunction : raw

  // Expected serial stream, first bit highest
  function automatic logic [15:0] stream(input logic [11:0] r, input logic [7:0] f, input int n);
    logic [11:0] v;
    logic        bt;
    v = r ^ (f[CTRL_BIP_BIT] ? BIP_FLIP : CODE_ZERO);
    stream = 16'h0000;
    for (int i = 0; i < n; i++) begin
      if (f[CTRL_LSB_FIRST_FLAG_BIT] && len_of(f) == 8) bt = (i < 8) ? v[i + 4] : 1'b0;
      else if (f[CTRL_LSB_FIRST_FLAG_BIT]) bt = (i < 12) ? v[i] : 1'b0;
      else bt = (i < 12) ? v[11 - i] : 1'b0;
      stream = {stream[14:0], bt};
    end
  endfunction : stream

  function automatic int len_of(input logic [7:0] b);
    len_of = (b[3:2] == LEN_CODE_8) ? 8 : ((b[3:2] == LEN_CODE_16) ? 16 : 12);
  endfunction : len_of

  // Access, compare previous result, optionally wait out the conversion
  task automatic xfer(input logic lo, input logic hi, input logic [7:0] b, input int n,
                      input bit chk, input bit wt);
    logic [15:0] cap;
    int          f0;
    int          k;
    int          s0;
    f0 = n_fall;
    s0 = n_samp;
    i_host.access(lo, hi, b, n, cap);
    if (chk) cmp_word("result stream", stream(res_q, fmt_q, n), cap);
    if (!wt) return;
    k = 0;
    while ((n_fall == f0 || eoc !== 1'b1) && k < 400) begin
      @(posedge clk);
      k++;
    end
    cmp_bit("conversion cycle", 1'b1, (n_fall != f0) && (eoc === 1'b1));
    cmp_bit("sampling window", 1'b1, n_samp != s0);
    cmp_bit("sample held", 1'b0, samp);
    if (b[7:4] != CH_PDOWN) begin
      res_q = raw(b[7:4]);
      fmt_q = b;
    end
  endtask : xfer

  task automatic t_power_up();
    cmp_bit("eoc", 1'b1, eoc);
    cmp_bit("oe", 1'b0, oe);
    cmp_bit("power down", 1'b0, pd);
    xfer(1'b1, 1'b1, 8'h30, 12, 1'b0, 1'b1);
    $display("test power_up done");
  endtask : t_power_up

  task automatic t_formats();
    logic [7:0] tab [10] = '{8'h14, 8'h2E, 8'hA9, 8'hB7, 8'hC3, 8'hDD, 8'h05, 8'h76, 8'hF0,
                             8'h90};
    foreach (tab[i]) xfer(1'b1, 1'b1, tab[i], len_of(tab[i]), 1'b1, 1'b1);
    $display("test formats done");
  endtask : t_formats

  task automatic t_held_low();
    xfer(1'b1, 1'b0, 8'h40, 12, 1'b1, 1'b1);
    xfer(1'b0, 1'b0, 8'h8C, 16, 1'b1, 1'b1);
    xfer(1'b0, 1'b1, 8'h50, 12, 1'b1, 1'b1);
    $display("test held_low done");
  endtask : t_held_low

  task automatic t_powerdown();
    xfer(1'b1, 1'b1, 8'hE0, 12, 1'b1, 1'b1);
    cmp_bit("power down set", 1'b1, pd);
    xfer(1'b1, 1'b1, 8'h20, 12, 1'b1, 1'b1);
    cmp_bit("power down clear", 1'b0, pd);
    $display("test powerdown done");
  endtask : t_powerdown

  task automatic t_abort();
    logic [15:0] cap;
    xfer(1'b1, 1'b1, 8'h10, 12, 1'b1, 1'b0);
    i_host.access(1'b1, 1'b0, 8'h00, 0, cap);
    cmp_bit("eoc after abort", 1'b1, eoc);
    xfer(1'b0, 1'b1, 8'h60, 12, 1'b1, 1'b1);
    $display("test abort done");
  endtask : t_abort

  task automatic t_resync();
    int f0;
    f0 = n_fall;
    xfer(1'b1, 1'b1, 8'hFF, 3, 1'b1, 1'b0);
    cmp_bit("no conversion", 1'b1, (n_fall == f0) && (eoc === 1'b1));
    xfer(1'b1, 1'b1, 8'h30, 12, 1'b1, 1'b1);
    $display("test resync done");
  endtask : t_resync

  initial begin
    rst = 1'b1;
    for (int k = 0; k < NUM_AIN; k++) ain[k * AIN_W +: AIN_W] = 14'(k * 373 + 29);
    ain[1 * AIN_W +: AIN_W] = 14'h3FFB;
    ain[2 * AIN_W +: AIN_W] = 14'h1388;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_power_up();
    t_formats();
    t_held_low();
    t_powerdown();
    t_abort();
    t_resync();
    complete_run();
  end
endmodule : sai_io_sequencer_tb_top
